// file: hdl/profile_store.sv
// profile store, registered read
// assumes one clock; software loads contents
`timescale 1ns/1ps

module profile_store #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 200,
   parameter int AW = 8
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   // read port
   input wire logic [AW-1:0] rd_addr_i,
   output logic [WIDTH-1:0] rd_data_o
);

   logic [WIDTH-1:0] mem [DEPTH];

   // ==================================================================
   // write; out-of-range addresses are dropped
   always_ff @(posedge mclk_i) begin
      if (wr_en_i && (32'(wr_addr_i) < DEPTH)) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read, one cycle of latency
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rd_data_o <= '0;
      end else if (32'(rd_addr_i) < DEPTH) begin
         rd_data_o <= mem[rd_addr_i];
      end else begin
         rd_data_o <= '0;
      end
   end

endmodule

// file: hdl/setpoint_profile_sequencer.sv
// profile sequencer top level
// assumes apb and control loop on mclk_i, power_lost_i from a pin
//
// Contract
// - twenty programs of nine segments, chained
// - selecting a program starts setpoint generation
// - zero segment time ends the program
// - deviation beyond tolerance halts profile advancement
// - zero tolerance disables the deviation check
// - program end starts its linked program
// - self or wrap links repeat forever
// - segment event mask drives alarms while running
// - only event-configured alarms follow segment events
// - nonzero tolerance waits for initial setpoint; a linked program starts its first segment without waiting
// - power return restarts the interrupted segment
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "sps_defines.svh"

module setpoint_profile_sequencer import sps_pkg::*; #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter int ALARMS = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // control loop
   input wire logic [15:0] process_value_i,
   output logic [15:0] setpoint_o,
   // power monitor pin, high while supply is lost
   input wire logic power_lost_i,
   // alarms and status
   output logic [ALARMS-1:0] event_alarm_o,
   output logic program_running_o,
   output logic irq_o
);

   // ==================================================================
   // declarations
   seq_state_t state;
   logic tick;
   logic [`WORD_W-1:0] rd_data;
   logic [`MEM_AW-1:0] rd_addr;
   logic [`MEM_AW-1:0] mem_addr;
   logic [4:0] mem_hi;
   logic mem_we;
   logic [ALARMS-1:0] alarm_event_en;
   logic [15:0] tolerance;
   logic [`IRQ_W-1:0] irq_status;
   logic [`IRQ_W-1:0] irq_mask;
   logic [`IRQ_W-1:0] irq_event;
   logic acc_wr;
   logic setup_rd;
   logic addr_ok;
   logic start_req;
   logic stop_req;
   logic [4:0] prog;
   logic [3:0] seg;
   logic [4:0] link_to;
   logic chained;
   logic [15:0] seg_start;
   logic [15:0] seg_target;
   logic [15:0] seg_time;
   logic [3:0] seg_events;
   logic [15:0] elapsed;
   logic [15:0] next_elapsed;
   logic out_of_tol;
   logic start_ok;
   logic held;
   logic pwr_meta;
   logic pwr_sync;
   logic pwr_last;
   logic restore_pend;
   logic [5:0] div_cnt;
   logic [32:0] div_num;
   logic [15:0] div_rem;
   logic [16:0] div_q;
   logic div_neg;
   logic [16:0] rem_shift;
   logic div_ge;
   logic [16:0] next_q;
   logic [16:0] diff;
   logic [16:0] diff_mag;
   logic [16:0] ramp_sum;

   // ==================================================================
   // helpers
   // magnitude of a signed difference
   function automatic logic [16:0] abs_dev(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] d;
      d = {a[15], a} - {b[15], b};
      abs_dev = d[16] ? (17'h00000 - d) : d;
   endfunction

   // store address of a segment
   function automatic logic [`MEM_AW-1:0] seg_addr(input logic [4:0] p, input logic [3:0] s);
      logic [11:0] a;
      a = 12'(p) * 12'(`SEGS_PER_PROGRAM) + 12'(s);
      seg_addr = a[`MEM_AW-1:0];
   endfunction

   // store address of a program header
   function automatic logic [`MEM_AW-1:0] hdr_addr(input logic [4:0] p);
      hdr_addr = `HDR_BASE + `MEM_AW'(p);
   endfunction

   // ==================================================================
   // sub-blocks
   profile_store #(
      .WIDTH(`WORD_W),
      .DEPTH(`MEM_DEPTH),
      .AW(`MEM_AW)
   ) u_store (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .wr_en_i(mem_we),
      .wr_addr_i(mem_addr),
      .wr_data_i({mem_hi, pwdata_i}),
      .rd_addr_i(rd_addr),
      .rd_data_o(rd_data)
   );

   time_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .tick_o(tick)
   );

   // ==================================================================
   // apb decode; zero wait states, unmapped offsets answer with pslverr
   assign pready_o = 1'b1;
   assign acc_wr = psel_i & penable_i & pwrite_i & addr_ok;
   assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   always_comb begin
      unique case (paddr_i)
         `REG_CTRL, `REG_PROG_SEL, `REG_TOLERANCE, `REG_MEM_ADDR, `REG_MEM_DATA_LO,
         `REG_MEM_DATA_HI, `REG_STATUS, `REG_SETPOINT, `REG_IRQ_STATUS,
         `REG_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // selects past the last program are ignored, except the stop code, which stops the run
   assign start_req = acc_wr & (paddr_i == `REG_PROG_SEL) & (pwdata_i[4:0] <= `LAST_PROG);
   assign stop_req = acc_wr & (paddr_i == `REG_PROG_SEL) & (pwdata_i[4:0] == `STOP_CODE);
   assign mem_we = acc_wr & (paddr_i == `REG_MEM_DATA_LO);

   // software-written configuration
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         alarm_event_en <= '0;
         tolerance <= 16'h0000;
         irq_mask <= '0;
         mem_hi <= 5'h00;
      end else if (acc_wr) begin
         unique case (paddr_i)
            `REG_CTRL: alarm_event_en <= pwdata_i[ALARMS-1:0];
            `REG_TOLERANCE: tolerance <= pwdata_i[15:0];
            `REG_IRQ_MASK: irq_mask <= pwdata_i[`IRQ_W-1:0];
            `REG_MEM_DATA_HI: mem_hi <= pwdata_i[4:0];
            default: ;
         endcase
      end
   end

   // store pointer; steps after each low-word write so a table loads in one burst
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mem_addr <= '0;
      end else if (acc_wr && (paddr_i == `REG_MEM_ADDR)) begin
         mem_addr <= pwdata_i[`MEM_AW-1:0];
      end else if (mem_we) begin
         mem_addr <= mem_addr + `MEM_AW'(1);
      end
   end

   // read data captured in the setup phase, shown in the access phase
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h00000000;
      end else if (setup_rd) begin
         unique case (paddr_i)
            `REG_CTRL: prdata_o <= 32'(alarm_event_en);
            `REG_PROG_SEL: prdata_o <= {23'h000000, program_running_o, 3'h0, prog};
            `REG_TOLERANCE: prdata_o <= {16'h0000, tolerance};
            `REG_MEM_ADDR: prdata_o <= 32'(mem_addr);
            `REG_MEM_DATA_HI: prdata_o <= {27'h0000000, mem_hi};
            `REG_STATUS: prdata_o <= {20'h00000, 4'(state), 2'h0, held, chained, seg};
            `REG_SETPOINT: prdata_o <= {16'h0000, setpoint_o};
            `REG_IRQ_STATUS: prdata_o <= 32'(irq_status);
            `REG_IRQ_MASK: prdata_o <= 32'(irq_mask);
            default: prdata_o <= 32'h00000000;
         endcase
      end
   end

   // ==================================================================
   // interrupts: sticky, write one to clear, a new event beats the clear
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         irq_status <= '0;
      end else if (acc_wr && (paddr_i == `REG_IRQ_STATUS)) begin
         irq_status <= (irq_status & ~pwdata_i[`IRQ_W-1:0]) | irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end
   assign irq_o = |(irq_status & irq_mask);

   // ==================================================================
   // power pin synchroniser
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pwr_meta <= 1'b0;
         pwr_sync <= 1'b0;
         pwr_last <= 1'b0;
      end else begin
         pwr_meta <= power_lost_i;
         pwr_sync <= pwr_meta;
         pwr_last <= pwr_sync;
      end
   end

   // remember a supply return until the run state can act on it
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         restore_pend <= 1'b0;
      end else if (pwr_last && !pwr_sync) begin
         restore_pend <= 1'b1;
      end else if ((state == S_RUN) || (state == S_IDLE)) begin
         restore_pend <= 1'b0;
      end
   end

   // ==================================================================
   // tolerance checks
   assign out_of_tol = (tolerance != 16'h0000) &&
                       (abs_dev(process_value_i, setpoint_o) > {1'b0, tolerance});
   assign start_ok = (tolerance == 16'h0000) ||
                     (abs_dev(process_value_i, seg_start) <= {1'b0, tolerance});
   assign next_elapsed = elapsed + 16'h0001;

   // ramp arithmetic: start + (target - start) * elapsed / time
   assign diff = {seg_target[15], seg_target} - {seg_start[15], seg_start};
   assign diff_mag = diff[16] ? (17'h00000 - diff) : diff;
   assign rem_shift = {div_rem, div_num[32]};
   assign div_ge = rem_shift >= {1'b0, seg_time};
   assign next_q = {div_q[15:0], div_ge};
   assign ramp_sum = div_neg ? ({seg_start[15], seg_start} - next_q)
                             : ({seg_start[15], seg_start} + next_q);

   // ==================================================================
   // sequencer; the divide takes 33 cycles, far shorter than a time unit
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= S_IDLE;
         prog <= 5'h00;
         seg <= 4'h0;
         link_to <= 5'h00;
         chained <= 1'b0;
         rd_addr <= '0;
         seg_start <= 16'h0000;
         seg_target <= 16'h0000;
         seg_time <= 16'h0000;
         seg_events <= 4'h0;
         elapsed <= 16'h0000;
         setpoint_o <= 16'h0000;
         held <= 1'b0;
         div_cnt <= 6'h00;
         div_num <= '0;
         div_rem <= 16'h0000;
         div_q <= '0;
         div_neg <= 1'b0;
         irq_event <= '0;
      end else begin
         irq_event <= '0;
         if (stop_req) begin
            state <= S_IDLE;
            seg_events <= 4'h0;
            held <= 1'b0;
         end else if (start_req) begin
            prog <= pwdata_i[4:0];
            chained <= 1'b0;
            rd_addr <= hdr_addr(pwdata_i[4:0]);
            seg_events <= 4'h0;
            held <= 1'b0;
            state <= S_HDR_RD;
         end else begin
            unique case (state)
               S_IDLE: ;
               S_HDR_RD: state <= S_HDR;
               S_HDR: begin
                  // header gives the link and the setpoint the first segment ramps from
                  link_to <= rd_data[`F_LINK_MSB:`F_LINK_LSB];
                  seg_start <= rd_data[`F_SP_MSB:`F_SP_LSB];
                  setpoint_o <= rd_data[`F_SP_MSB:`F_SP_LSB];
                  seg <= 4'h0;
                  rd_addr <= seg_addr(prog, 4'h0);
                  state <= chained ? S_SEG_RD : S_START_WAIT;
               end
               S_START_WAIT: begin
                  if (start_ok) begin
                     state <= S_SEG_RD;
                  end
               end
               S_SEG_RD: state <= S_SEG;
               S_SEG: begin
                  if (rd_data[`F_TIME_MSB:`F_TIME_LSB] == 16'h0000) begin
                     // a zero time closes the program; later segments stay unread
                     irq_event[`IRQ_PROG_DONE] <= 1'b1;
                     prog <= link_to;
                     chained <= 1'b1;
                     seg_events <= 4'h0;
                     rd_addr <= hdr_addr(link_to);
                     state <= S_HDR_RD;
                  end else begin
                     seg_target <= rd_data[`F_SP_MSB:`F_SP_LSB];
                     seg_time <= rd_data[`F_TIME_MSB:`F_TIME_LSB];
                     seg_events <= rd_data[`F_EV_MSB:`F_EV_LSB];
                     elapsed <= 16'h0000;
                     state <= S_RUN;
                  end
               end
               S_RUN: begin
                  if (restore_pend) begin
                     // supply came back: the interrupted segment starts over
                     elapsed <= 16'h0000;
                     setpoint_o <= seg_start;
                  end else if (pwr_sync) begin
                     held <= 1'b1;
                  end else if (out_of_tol) begin
                     if (!held) begin
                        irq_event[`IRQ_HOLD] <= 1'b1;
                     end
                     held <= 1'b1;
                  end else begin
                     held <= 1'b0;
                     if (tick) begin
                        elapsed <= next_elapsed;
                        if (next_elapsed == seg_time) begin
                           setpoint_o <= seg_target;
                           seg_start <= seg_target;
                           irq_event[`IRQ_SEG_DONE] <= 1'b1;
                           if (seg == `LAST_SEG) begin
                              irq_event[`IRQ_PROG_DONE] <= 1'b1;
                              prog <= link_to;
                              chained <= 1'b1;
                              seg_events <= 4'h0;
                              rd_addr <= hdr_addr(link_to);
                              state <= S_HDR_RD;
                           end else begin
                              seg <= seg + 4'h1;
                              rd_addr <= seg_addr(prog, seg + 4'h1);
                              state <= S_SEG_RD;
                           end
                        end else begin
                           div_num <= 33'(diff_mag * 33'(next_elapsed));
                           div_neg <= diff[16];
                           div_rem <= 16'h0000;
                           div_q <= '0;
                           div_cnt <= 6'h00;
                           state <= S_DIVIDE;
                        end
                     end
                  end
               end
               S_DIVIDE: begin
                  // restoring divide, one quotient bit a cycle
                  div_num <= {div_num[31:0], 1'b0};
                  div_q <= next_q;
                  div_rem <= div_ge ? 16'(rem_shift - {1'b0, seg_time}) : rem_shift[15:0];
                  div_cnt <= div_cnt + 6'h01;
                  if (div_cnt == `DIV_LAST) begin
                     setpoint_o <= ramp_sum[15:0];
                     state <= S_RUN;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // ==================================================================
   // alarm and run outputs
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         event_alarm_o <= '0;
         program_running_o <= 1'b0;
      end else begin
         event_alarm_o <= ALARMS'(seg_events) & alarm_event_en;
         program_running_o <= (state != S_IDLE);
      end
   end

endmodule

// file: hdl/sps_defines.svh
// sequencer constants
// assumes inclusion by bare name
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// ==================================================================
// profile store sizes
`define SEGS_PER_PROGRAM 9
`define MEM_DEPTH 200
`define MEM_AW 8
`define WORD_W 37
`define HDR_BASE 8'hB4
`define LAST_PROG 5'h13
`define LAST_SEG 4'h8
`define STOP_CODE 5'h1F

// ==================================================================
// word layout: segment {events, time, target}, header {link, initial setpoint}
`define F_SP_LSB 0
`define F_SP_MSB 15
`define F_TIME_LSB 16
`define F_TIME_MSB 31
`define F_EV_LSB 32
`define F_EV_MSB 35
`define F_LINK_LSB 32
`define F_LINK_MSB 36

// ==================================================================
// apb register byte offsets
`define REG_CTRL 12'h000
`define REG_PROG_SEL 12'h004
`define REG_TOLERANCE 12'h008
`define REG_MEM_ADDR 12'h00C
`define REG_MEM_DATA_LO 12'h010
`define REG_MEM_DATA_HI 12'h014
`define REG_STATUS 12'h018
`define REG_SETPOINT 12'h01C
`define REG_IRQ_STATUS 12'h020
`define REG_IRQ_MASK 12'h024

// ==================================================================
// interrupt bits
`define IRQ_SEG_DONE 0
`define IRQ_PROG_DONE 1
`define IRQ_HOLD 2
`define IRQ_W 3

// ==================================================================
// timing: one profile time unit is one second
`define CLK_MHZ 200
`define TIME_UNIT_MS 1000
`define TICK_CYCLES (`TIME_UNIT_MS * 1000 * `CLK_MHZ)
`define DIV_LAST 6'h20

`endif

// file: hdl/sps_pkg.sv
// sequencer types
// assumes nothing beyond a systemverilog compiler
package sps_pkg;

   // ==================================================================
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE,
      S_HDR_RD,
      S_HDR,
      S_START_WAIT,
      S_SEG_RD,
      S_SEG,
      S_RUN,
      S_DIVIDE
   } seq_state_t;

endpackage

// file: hdl/time_tick.sv
// time base enable pulse
// assumes one clock
`timescale 1ns/1ps

module time_tick #(
   parameter int CYCLES = 200000000
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // enable pulse
   output logic tick_o
);

   logic [31:0] count;

   // ==================================================================
   // free-running divider, so segment time never drifts with restarts
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         count <= 32'h00000000;
         tick_o <= 1'b0;
      end else if (count == 32'(CYCLES - 1)) begin
         count <= 32'h00000000;
         tick_o <= 1'b1;
      end else begin
         count <= count + 32'h00000001;
         tick_o <= 1'b0;
      end
   end

endmodule

// file: verif/control_loop_model.sv
// control loop model: process value follows the setpoint one cycle late
// assumes the bench sets the deviation
`timescale 1ns/1ps
module control_loop_model (
   // clock
   input wire logic mclk_i,
   // setpoint in, deviation from the bench, process value out
   input wire logic [15:0] setpoint_i,
   input wire logic [15:0] offset_i,
   output logic [15:0] process_value_o
);
   // ==================================================================
   // one cycle lag, so every step shows a brief deviation, like a real loop
   always_ff @(posedge mclk_i) begin
      process_value_o <= setpoint_i + offset_i;
   end
endmodule

// file: verif/setpoint_profile_sequencer_tb.sv
// self-checking bench of the setpoint profile sequencer
// assumes the loop model; short time unit
`timescale 1ns/1ps
`include "sps_defines.svh"
module setpoint_profile_sequencer_tb;
   // ==================================================================
   // signals, tables and counters
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;} row_t;
   typedef struct {logic [7:0] a; logic [4:0] h; logic [31:0] l;} word_t;
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
   logic pwrite_i = 1'b0, power_lost_i = 1'b0, pready_o, pslverr_o, running, irq_o, er;
   logic [11:0] paddr_i = 12'h0;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rv;
   logic [15:0] offset = 16'h0, pv, setpoint_o, hv;
   logic [3:0] alarm;
   int bad_count = 0, total_checks = 0;
   row_t rows[12] = '{'{0, `REG_CTRL, 32'h0, 0}, '{0, `REG_TOLERANCE, 32'h0, 0},
      '{0, `REG_IRQ_MASK, 32'h0, 0}, '{0, `REG_STATUS, 32'h0, 0}, '{0, `REG_SETPOINT, 32'h0, 0},
      '{1, `REG_CTRL, 32'hF, 0}, '{0, `REG_CTRL, 32'hF, 0}, '{1, `REG_TOLERANCE, 32'h1234, 0},
      '{0, `REG_TOLERANCE, 32'h1234, 0}, '{1, 12'h030, 32'h0, 1}, '{0, 12'h030, 32'h0, 1},
      '{0, `REG_MEM_DATA_LO, 32'h0, 0}};
   word_t wd[7] = '{'{8'h00, 5'h05, 32'h0004_0064}, '{8'h01, 5'h0A, 32'h0002_0064},
      '{8'h02, 5'h00, 32'h0}, '{8'h09, 5'h00, 32'h0001_0032}, '{8'h0A, 5'h00, 32'h0},
      '{8'hB4, 5'h01, 32'h0000_0014}, '{8'hB5, 5'h00, 32'h0000_0028}};
   always #2.5 mclk_i = ~mclk_i;
   setpoint_profile_sequencer #(.TICK_CYCLES(64), .ALARMS(4)) dut (.mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .process_value_i(pv), .setpoint_o(setpoint_o),
      .power_lost_i(power_lost_i), .event_alarm_o(alarm), .program_running_o(running),
      .irq_o(irq_o));
   control_loop_model loop (.mclk_i(mclk_i), .setpoint_i(setpoint_o), .offset_i(offset),
      .process_value_o(pv));
   // ==================================================================
   // verdict, comparison, bus cycle and setpoint wait
   task results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // request held until ready is sampled high, then released
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 50);
      rv = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
      if (n >= 50) begin bad_count++; results(); end
   endtask
   task wsp(input logic [15:0] e);
      int n;
      n = 0;
      hv = setpoint_o;
      while (setpoint_o === hv && n < 600) begin @(negedge mclk_i); n++; end
      if (n >= 600) begin bad_count++; results(); end
      chk("setpoint", {16'h0, e}, {16'h0, setpoint_o});
   endtask
   // ==================================================================
   // table rows, store load, hand-written cases
   initial begin
      repeat (10) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("read", rows[i].d, rv);
         chk("refusal", {31'h0, rows[i].e}, {31'h0, er});
      end
      foreach (wd[i]) begin
         apb(1'b1, `REG_MEM_ADDR, {24'h0, wd[i].a});
         apb(1'b1, `REG_MEM_DATA_HI, {27'h0, wd[i].h});
         apb(1'b1, `REG_MEM_DATA_LO, wd[i].l);
      end
      $display("registers and store done");
      apb(1'b1, `REG_CTRL, 32'h3); apb(1'b1, `REG_TOLERANCE, 32'h0); apb(1'b1, `REG_IRQ_MASK, 32'h4);
      offset <= 16'h0032;
      apb(1'b1, `REG_PROG_SEL, 32'h0);
      repeat (3) @(negedge mclk_i);
      chk("start", 32'h14, {16'h0, setpoint_o});
      wsp(16'h0028);
      chk("alarm", 32'h1, {28'h0, alarm});
      wsp(16'h003C); wsp(16'h0050); wsp(16'h0064);
      repeat (10) @(negedge mclk_i);
      chk("alarm", 32'h2, {28'h0, alarm});
      wsp(16'h0028);
      wsp(16'h0032); wsp(16'h0014);
      chk("masked irq", 32'h0, {31'h0, irq_o});
      apb(1'b1, `REG_PROG_SEL, 32'h1F); apb(1'b1, `REG_PROG_SEL, 32'h14); apb(1'b0, `REG_PROG_SEL, 32'h0);
      chk("idle", 32'h0, {31'h0, rv[8]});
      $display("chain done");
      apb(1'b1, `REG_TOLERANCE, 32'h5); apb(1'b1, `REG_PROG_SEL, 32'h0);
      repeat (300) @(negedge mclk_i);
      chk("start wait", 32'h14, {16'h0, setpoint_o});
      @(posedge mclk_i) offset <= 16'h0;
      wsp(16'h0028);
      @(posedge mclk_i) power_lost_i <= 1'b1;
      repeat (150) @(negedge mclk_i);
      chk("frozen", 32'h28, {16'h0, setpoint_o});
      @(posedge mclk_i) power_lost_i <= 1'b0;
      repeat (6) @(negedge mclk_i);
      chk("restart", 32'h14, {16'h0, setpoint_o});
      wsp(16'h0028);
      $display("power done");
      @(posedge mclk_i) offset <= 16'h0032;
      repeat (50) @(negedge mclk_i);
      hv = setpoint_o;
      repeat (200) @(negedge mclk_i);
      chk("hold", {16'h0, hv}, {16'h0, setpoint_o});
      chk("hold irq", 32'h1, {31'h0, irq_o});
      apb(1'b1, `REG_IRQ_STATUS, 32'h4);
      @(negedge mclk_i);
      chk("irq clear", 32'h0, {31'h0, irq_o});
      @(posedge mclk_i) offset <= 16'h0;
      wsp(hv + 16'h0014);
      $display("hold done");
      results();
   end
endmodule

// file: verif/sps_chk.sv
// sequencer checker on top ports
// assumes one clock
`timescale 1ns/1ps
`include "sps_defines.svh"
module sps_chk #(
   parameter int TICK_CYCLES = 64,
   parameter int ALARMS = 4
) (
   // clock, reset, apb
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // loop, power, alarms
   input wire logic [15:0] process_value_i,
   input wire logic [15:0] setpoint_o,
   input wire logic power_lost_i,
   input wire logic [ALARMS-1:0] event_alarm_o,
   input wire logic program_running_o,
   input wire logic irq_o
);
   // ==================================================================
   // register shadows and quiet-window counts
   logic [15:0] tol;
   logic [ALARMS-1:0] ctrl;
   logic [2:0] mask;
   logic signed [16:0] dv;
   logic wr;
   logic over;
   logic [5:0] hc;
   logic [5:0] pc;
   assign wr = psel_i && penable_i && pwrite_i;
   assign dv = $signed({process_value_i[15], process_value_i}) - $signed({setpoint_o[15], setpoint_o});
   assign over = (tol != 16'h0) && (dv > $signed({1'b0, tol}) || -dv > $signed({1'b0, tol}));
   // same edge as the design
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tol <= 16'h0;
         ctrl <= '0;
         mask <= 3'h0;
      end else if (wr) begin
         case (paddr_i)
            `REG_TOLERANCE: tol <= pwdata_i[15:0];
            `REG_CTRL: ctrl <= pwdata_i[ALARMS-1:0];
            `REG_IRQ_MASK: mask <= pwdata_i[2:0];
            default: ;
         endcase
      end
   end
   // 40 quiet cycles outlast a divide already in flight
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         hc <= 6'h00;
         pc <= 6'h00;
      end else begin
         hc <= (psel_i || power_lost_i || !over) ? 6'h00 : hc + 6'(hc != 6'h3F);
         pc <= (psel_i || !power_lost_i) ? 6'h00 : pc + 6'(pc != 6'h3F);
      end
   end
   // ==================================================================
   // properties
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   sequence sel_wr;
      wr && paddr_i == `REG_PROG_SEL;
   endsequence
   AST_START: assert property (sel_wr ##0 pwdata_i < 32'h14 |-> ##2 program_running_o)
      else $error("program did not start");
   AST_STOP: assert property (sel_wr ##0 pwdata_i == 32'h1F |-> ##2 !program_running_o)
      else $error("program did not stop");
   AST_BADSEL: assert property (sel_wr ##0 (pwdata_i == 32'h14 && !program_running_o)
      |-> ##2 !program_running_o)
      else $error("bad select started");
   AST_HOLD: assert property (hc >= 6'h28 |-> $stable(setpoint_o))
      else $error("setpoint moved in hold");
   AST_POWER: assert property (pc >= 6'h28 |-> $stable(setpoint_o))
      else $error("setpoint moved without power");
   AST_ALMASK: assert property ((event_alarm_o & ~(ctrl | $past(ctrl))) == '0)
      else $error("non-event alarm driven");
   AST_ALIDLE: assert property (!program_running_o && !$past(program_running_o)
      |-> event_alarm_o == '0)
      else $error("alarm active while idle");
   AST_UNMAP: assert property (psel_i && penable_i && paddr_i > `REG_IRQ_MASK |-> pslverr_o)
      else $error("unmapped access not refused");
   AST_IRQ: assert property (irq_o |-> mask != 3'h0)
      else $error("irq while masked");
   AST_READY: assert property (pready_o)
      else $error("ready low");
endmodule
bind setpoint_profile_sequencer sps_chk #(.TICK_CYCLES(TICK_CYCLES), .ALARMS(ALARMS)) chk_i (.*);
